// ### rtl/afc_pkg.sv
package afc_pkg;
  localparam logic [7:0] OFF_CH8_PHASE   = 8'h63;
  localparam logic [7:0] OFF_FILTER_CFG  = 8'h6B;
  localparam logic [7:0] OFF_VOL_BIQUAD  = 8'h6C;
  localparam logic [7:0] OFF_RANGE_ENH   = 8'h6D;
  localparam logic [7:0] RST_CH8_PHASE   = 8'h00;
  localparam logic [7:0] RST_FILTER_CFG  = 8'h01;
  localparam logic [7:0] RST_VOL_BIQUAD  = 8'h40;
  localparam logic [7:0] RST_RANGE_ENH   = 8'h7B;
  localparam logic [7:0] MASK_FILTER_CFG = 8'h3F;
  localparam int         POS_DECIM       = 4;
  localparam int         POS_SUM         = 2;
  localparam int         POS_HPF         = 0;
  localparam int         POS_GANG        = 7;
  localparam int         POS_BIQUAD      = 5;
  localparam int         POS_SOFTOFF     = 4;
  localparam int         POS_GAINSEL     = 3;
  localparam int         POS_THRESH      = 4;
  localparam int         POS_GAINLIM     = 0;
  localparam logic [3:0] THRESH_MAX      = 4'h9;
  localparam logic [3:0] GAINLIM_MAX     = 4'hC;
  typedef enum logic [1:0] {DEC_LINEAR, DEC_LOWLAT, DEC_ULTRALOW, DEC_RSVD} afc_decim_t;
  typedef enum logic [1:0] {SUM_OFF, SUM_PAIRS, SUM_QUAD, SUM_RSVD} afc_sum_t;
  typedef enum logic [1:0] {HPF_PROG, HPF_CUT1, HPF_CUT2, HPF_CUT3} afc_hpf_t;
endpackage

// ### rtl/afc_phase_delay.sv
`timescale 1ns/1ps
module afc_phase_delay #(
  parameter int DEPTH = 256
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       modTick,
  input  wire logic       pdmIn,
  input  wire logic [7:0] delayCount,
  input  wire logic       pdmMode,
  output logic            pdmOut
);
  import afc_pkg::*;
  logic [DEPTH-1:0] shiftReg;
  logic [DEPTH-1:0] next_shiftReg;
  logic             next_pdmOut;

  always_comb begin
    next_shiftReg = shiftReg;
    if (modTick) begin
      next_shiftReg = {shiftReg[DEPTH-2:0], pdmIn};
    end
    // Tap 0 is the bit taken one tick ago, so N=0 bypasses the line
    if (!pdmMode || delayCount == 8'h00) begin
      next_pdmOut = pdmIn;
    end else begin
      // Hold between ticks; the tap moves after each shift
      next_pdmOut = modTick ? shiftReg[delayCount - 8'h01] : pdmOut;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shiftReg <= '0;
      pdmOut   <= 1'b0;
    end else begin
      shiftReg <= next_shiftReg;
      pdmOut   <= next_pdmOut;
    end
  end
endmodule // afc_phase_delay

// ### rtl/afc_channel_sum.sv
`timescale 1ns/1ps
module afc_channel_sum #(
  parameter int W = 24
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          sampleStrobe,
  input  wire logic [1:0]    sumMode,
  input  wire logic [W-1:0]  ch1,
  input  wire logic [W-1:0]  ch2,
  input  wire logic [W-1:0]  ch3,
  input  wire logic [W-1:0]  ch4,
  output logic [W-1:0]       out1,
  output logic [W-1:0]       out2,
  output logic [W-1:0]       out3,
  output logic [W-1:0]       out4
);
  import afc_pkg::*;
  logic [W+1:0] pairA;
  logic [W+1:0] pairB;
  logic [W+1:0] quad;
  logic [W-1:0] next_out1;
  logic [W-1:0] next_out2;
  logic [W-1:0] next_out3;
  logic [W-1:0] next_out4;

  // Signed widening so averages never overflow
  function automatic logic [W+1:0] sx(input logic [W-1:0] v);
    sx = {{2{v[W-1]}}, v};
  endfunction

  always_comb begin
    pairA     = sx(ch1) + sx(ch2);
    pairB     = sx(ch3) + sx(ch4);
    quad      = pairA + pairB;
    next_out1 = out1;
    next_out2 = out2;
    next_out3 = out3;
    next_out4 = out4;
    if (sampleStrobe) begin
      unique case (afc_sum_t'(sumMode))
        SUM_PAIRS: begin
          next_out1 = pairA[W:1];
          next_out2 = pairB[W:1];
          next_out3 = '0;
          next_out4 = '0;
        end
        SUM_QUAD: begin
          next_out1 = quad[W+1:2];
          next_out2 = '0;
          next_out3 = '0;
          next_out4 = '0;
        end
        // Reserved code passes channels through, same as off
        SUM_OFF, SUM_RSVD: begin
          next_out1 = ch1;
          next_out2 = ch2;
          next_out3 = ch3;
          next_out4 = ch4;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out1 <= '0;
      out2 <= '0;
      out3 <= '0;
      out4 <= '0;
    end else begin
      out1 <= next_out1;
      out2 <= next_out2;
      out3 <= next_out3;
      out4 <= next_out4;
    end
  end
endmodule // afc_channel_sum

// ### rtl/afc_filter_chain_config.sv
`timescale 1ns/1ps
module afc_filter_chain_config #(
  parameter int W = 24
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          regWrite,
  input  wire logic          regRead,
  input  wire logic [7:0]    regAddr,
  input  wire logic [7:0]    regWdata,
  output logic [7:0]         regRdata,
  output logic               regHit,
  input  wire logic          modTick,
  input  wire logic          ch8PdmMode,
  input  wire logic          ch8PdmIn,
  output logic               ch8PdmOut,
  input  wire logic          sampleStrobe,
  input  wire logic [W-1:0]  ch1,
  input  wire logic [W-1:0]  ch2,
  input  wire logic [W-1:0]  ch3,
  input  wire logic [W-1:0]  ch4,
  output logic [W-1:0]       out1,
  output logic [W-1:0]       out2,
  output logic [W-1:0]       out3,
  output logic [W-1:0]       out4,
  output logic [1:0]         decimationResponseSelect,
  output logic [1:0]         highpassSelect,
  output logic               highpassProgrammable,
  output logic               volumeGang,
  output logic [1:0]         biquadCount,
  output logic [2:0]         biquadEnable,
  output logic               softStepEnable,
  output logic               gainFunctionSelect,
  output logic               rangeEnhancerActive,
  output logic               agcActive,
  output logic [3:0]         rangeEnhancerThreshold,
  output logic [3:0]         rangeEnhancerGainLimit,
  output logic               configReserved
);
  import afc_pkg::*;
  logic [7:0] channel8PhaseDelay;
  logic [7:0] filterChainConfig;
  logic [7:0] volumeBiquadConfig;
  logic [7:0] rangeEnhancerConfig;
  logic [7:0] next_channel8PhaseDelay;
  logic [7:0] next_filterChainConfig;
  logic [7:0] next_volumeBiquadConfig;
  logic [7:0] next_rangeEnhancerConfig;
  logic [7:0] next_regRdata;

  // Register writes; reserved top bits of the filter register stay zero
  always_comb begin
    next_channel8PhaseDelay  = channel8PhaseDelay;
    next_filterChainConfig   = filterChainConfig;
    next_volumeBiquadConfig  = volumeBiquadConfig;
    next_rangeEnhancerConfig = rangeEnhancerConfig;
    if (regWrite) begin
      unique case (regAddr)
        OFF_CH8_PHASE:  next_channel8PhaseDelay  = regWdata;
        OFF_FILTER_CFG: next_filterChainConfig   = regWdata & MASK_FILTER_CFG;
        OFF_VOL_BIQUAD: next_volumeBiquadConfig  = regWdata;
        OFF_RANGE_ENH:  next_rangeEnhancerConfig = regWdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    next_regRdata = 8'h00;
    if (regRead) begin
      unique case (regAddr)
        OFF_CH8_PHASE:  next_regRdata = channel8PhaseDelay;
        OFF_FILTER_CFG: next_regRdata = filterChainConfig;
        OFF_VOL_BIQUAD: next_regRdata = volumeBiquadConfig;
        OFF_RANGE_ENH:  next_regRdata = rangeEnhancerConfig;
        default:        next_regRdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    regHit = (regAddr == OFF_CH8_PHASE) || (regAddr == OFF_FILTER_CFG) ||
             (regAddr == OFF_VOL_BIQUAD) || (regAddr == OFF_RANGE_ENH);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      channel8PhaseDelay  <= RST_CH8_PHASE;
      filterChainConfig   <= RST_FILTER_CFG;
      volumeBiquadConfig  <= RST_VOL_BIQUAD;
      rangeEnhancerConfig <= RST_RANGE_ENH;
      regRdata            <= 8'h00;
    end else begin
      channel8PhaseDelay  <= next_channel8PhaseDelay;
      filterChainConfig   <= next_filterChainConfig;
      volumeBiquadConfig  <= next_volumeBiquadConfig;
      rangeEnhancerConfig <= next_rangeEnhancerConfig;
      regRdata            <= next_regRdata;
    end
  end

  // Field decode: combinational from registers, which are flops
  always_comb begin
    decimationResponseSelect = filterChainConfig[POS_DECIM +: 2];
    highpassSelect           = filterChainConfig[POS_HPF +: 2];
    highpassProgrammable     = afc_hpf_t'(highpassSelect) == HPF_PROG;
    volumeGang               = volumeBiquadConfig[POS_GANG];
    biquadCount              = volumeBiquadConfig[POS_BIQUAD +: 2];
    biquadEnable             = 3'h0;
    for (int i = 0; i < 3; i++) begin
      biquadEnable[i] = (2'(i) < biquadCount);
    end
    softStepEnable           = !volumeBiquadConfig[POS_SOFTOFF];
    gainFunctionSelect       = volumeBiquadConfig[POS_GAINSEL];
    rangeEnhancerActive      = !gainFunctionSelect;
    agcActive                = gainFunctionSelect;
    rangeEnhancerThreshold   = rangeEnhancerConfig[POS_THRESH +: 4];
    rangeEnhancerGainLimit   = rangeEnhancerConfig[POS_GAINLIM +: 4];
    // Reserved codes are flagged, not corrected; software owns the fix
    configReserved = (afc_decim_t'(decimationResponseSelect) == DEC_RSVD) ||
                     (afc_sum_t'(filterChainConfig[POS_SUM +: 2]) == SUM_RSVD) ||
                     (rangeEnhancerThreshold > THRESH_MAX) ||
                     (rangeEnhancerGainLimit > GAINLIM_MAX);
  end

  afc_phase_delay u_phase (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .modTick    (modTick),
    .pdmIn      (ch8PdmIn),
    .delayCount (channel8PhaseDelay),
    .pdmMode    (ch8PdmMode),
    .pdmOut     (ch8PdmOut)
  );

  afc_channel_sum #(.W(W)) u_sum (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .sampleStrobe (sampleStrobe),
    .sumMode      (filterChainConfig[POS_SUM +: 2]),
    .ch1          (ch1),
    .ch2          (ch2),
    .ch3          (ch3),
    .ch4          (ch4),
    .out1         (out1),
    .out2         (out2),
    .out3         (out3),
    .out4         (out4)
  );
endmodule // afc_filter_chain_config

// ### verif/afc_chain_monitor.sv
`timescale 1ns/1ps
module afc_chain_monitor (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       ch8PdmMode,
  input wire logic       ch8PdmIn,
  input wire logic       ch8PdmOut,
  input wire logic [1:0] decimationResponseSelect,
  input wire logic [1:0] highpassSelect,
  input wire logic       highpassProgrammable,
  input wire logic       volumeGang,
  input wire logic [1:0] biquadCount,
  input wire logic [2:0] biquadEnable,
  input wire logic       softStepEnable,
  input wire logic       gainFunctionSelect,
  input wire logic [3:0] rangeEnhancerThreshold,
  input wire logic [3:0] rangeEnhancerGainLimit,
  input wire logic       configReserved
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Decodes are levels, so a write shows one edge later
  a_reset_vals: assert property (
    $past(sys_rst) |-> biquadCount == 2'h2 && highpassSelect == 2'h1 && {rangeEnhancerThreshold,
    rangeEnhancerGainLimit} == 8'h7B) else $error("reset decode wrong");
  a_dsp1_write: assert property (
    regWrite && regAddr == 8'h6C |=> volumeGang == $past(regWdata[7]) && softStepEnable == !$past(regWdata[4])
    && gainFunctionSelect == $past(regWdata[3])) else $error("volume config decode wrong");
  a_filter_write: assert property (
    regWrite && regAddr == 8'h6B |=> decimationResponseSelect == $past(regWdata[5:4])
    && highpassSelect == $past(regWdata[1:0])) else $error("filter decode wrong");
  a_enh_write: assert property (
    regWrite && regAddr == 8'h6D |=> {rangeEnhancerThreshold, rangeEnhancerGainLimit} == $past(regWdata))
    else $error("enhancer decode wrong");
  a_biquad_map: assert property (
    biquadEnable == {biquadCount == 2'h3, biquadCount >= 2'h2, biquadCount != 2'h0})
    else $error("biquad enable wrong");
  a_hpf_prog: assert property (
    highpassProgrammable == (highpassSelect == 2'h0)) else $error("programmable highpass wrong");
  a_reserved_flag: assert property (
    decimationResponseSelect == 2'h3 || rangeEnhancerThreshold > 4'h9 || rangeEnhancerGainLimit > 4'hC
    |-> configReserved) else $error("reserved flag missing");
  a_pdm_bypass: assert property (
    !ch8PdmMode && $past(!ch8PdmMode) && !$past(sys_rst) |-> ch8PdmOut == $past(ch8PdmIn))
    else $error("pdm bypass wrong");
endmodule // afc_chain_monitor

bind afc_filter_chain_config afc_chain_monitor u_mon (.*);

// ### verif/audio_filter_chain_config_test.sv
`timescale 1ns/1ps
module audio_filter_chain_config_test;
  import afc_pkg::*;
  logic        core_clk, sys_rst, regWrite, regRead, regHit, modTick, ch8PdmMode, ch8PdmIn, ch8PdmOut;
  logic        sampleStrobe, highpassProgrammable, volumeGang, softStepEnable, gainFunctionSelect;
  logic        rangeEnhancerActive, agcActive, configReserved;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic [1:0]  decimationResponseSelect, highpassSelect, biquadCount;
  logic [2:0]  biquadEnable;
  logic [3:0]  rangeEnhancerThreshold, rangeEnhancerGainLimit;
  logic [23:0] ch1, ch2, ch3, ch4, out1, out2, out3, out4;
  int          err_count, compares;
  afc_filter_chain_config u_dut (.*);
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrite = 1;
    regAddr = a;
    regWdata = d;
    step(1);
    regWrite = 0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regRead = 1;
    regAddr = a;
    step(1);
    regRead = 0;
    chk(regRdata, e);
    step(1);
  endtask
  task automatic t_reset;
    rd(8'h63, 8'h00);
    chk(regHit, 1'b1);
    rd(8'h6B, 8'h01);
    rd(8'h6C, 8'h40);
    rd(8'h6D, 8'h7B);
    rd(8'h60, 8'h00);
    chk(regHit, 1'b0);
  endtask
  task automatic t_filter;
    for (int i = 0; i < 4; i++) begin
      wr(8'h6B, {2'h3, i[1:0], 2'h0, 2'(3 - i)});
      chk(decimationResponseSelect, i);
      chk(highpassSelect, 3 - i);
      chk(highpassProgrammable, i == 3);
      chk(configReserved, i == 3);
      rd(8'h6B, {2'h0, i[1:0], 2'h0, 2'(3 - i)});
    end
    wr(8'h6B, 8'h01);
    wr(8'h6D, 8'hAC);
    chk(configReserved, 1);
    wr(8'h6D, 8'h9D);
    chk(configReserved, 1);
    wr(8'h6D, 8'h9C);
    chk(configReserved, 0);
    rd(8'h6D, 8'h9C);
  endtask
  task automatic t_dsp1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h6C, {i[0], i[1:0], i[1], i[0], 3'h5});
      chk(volumeGang, i[0]);
      chk(biquadEnable, (1 << i) - 1);
      chk(softStepEnable, !i[1]);
      chk(gainFunctionSelect, i[0]);
      chk(agcActive, i[0]);
      chk(rangeEnhancerActive, !i[0]);
      rd(8'h6C, {i[0], i[1:0], i[1], i[0], 3'h5});
    end
  endtask
  task automatic strobe(input logic [7:0] cfg);
    wr(8'h6B, cfg);
    sampleStrobe = 1;
    step(1);
    sampleStrobe = 0;
  endtask
  task automatic t_sum;
    // Odd negative pair sum checks floor rounding
    ch1 = 24'h000010;
    ch2 = 24'hFFFFED;
    ch3 = 24'h000020;
    ch4 = 24'h000021;
    strobe(8'h05);
    chk(out1, 24'hFFFFFE);
    chk(out2, 24'h000020);
    strobe(8'h09);
    chk(out1, 24'h00000F);
    chk(out4, 24'h000000);
    strobe(8'h01);
    chk(out2, 24'hFFFFED);
    chk(out3, 24'h000020);
  endtask
  function automatic logic pbit(input int j);
    return j[0] ^ j[2];
  endfunction
  task automatic pdm(input int n, input logic m);
    int d;
    d = m ? n : 0;
    ch8PdmMode = m;
    wr(8'h63, n[7:0]);
    for (int k = 0; k < n + 6; k++) begin
      ch8PdmIn = pbit(k);
      modTick = 1;
      step(1);
      modTick = 0;
      step(1);
      if (k >= d) chk(ch8PdmOut, pbit(k - d));
    end
  endtask
  task automatic summarize;
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    // Guards against a stuck run
    #2000000;
    err_count++;
    summarize;
  end
  initial begin
    {regWrite, regRead, modTick, ch8PdmMode, ch8PdmIn, sampleStrobe} = 6'h00;
    {regAddr, regWdata} = 16'h0000;
    {ch1, ch2, ch3, ch4} = 96'h0;
    err_count = 0;
    compares = 0;
    sys_rst = 1;
    step(10);
    sys_rst = 0;
    t_reset;
    t_filter;
    t_dsp1;
    t_sum;
    pdm(3, 1);
    pdm(255, 1);
    pdm(0, 1);
    pdm(3, 0);
    wr(8'h6D, 8'h12);
    sys_rst = 1;
    step(2);
    sys_rst = 0;
    t_reset;
    summarize;
  end
endmodule // audio_filter_chain_config_test
